// ---- verilog/sample_timing_pkg.sv ----
// sample timing controller: register map, reset values, field positions
// assumes an 8-bit register port and a single 25 MHz master clock
package sample_timing_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] input_timing_config_a_off = 8'h00; // mode bit 0
  localparam logic [7:0] sample_phase_config_off   = 8'h02; // coarse phase, mode bits
  localparam logic [7:0] input_timing_config_b_off = 8'h04; // sync edge, mode bit
  localparam logic [7:0] input_timing_config_c_off = 8'h05; // mode bit
  localparam logic [7:0] sample_trailing_edge_off  = 8'h36; // trailing edge code
  localparam logic [7:0] channel_config_off        = 8'h07; // channel arrangement
  localparam logic [7:0] timing_status_off         = 8'h08; // read-only state

  // ------------------------------------------------------------
  // reset values (delay-line clocked mode after reset)
  // ------------------------------------------------------------
  localparam logic [7:0] input_timing_config_a_rst = 8'h00;
  localparam logic [7:0] sample_phase_config_rst   = 8'h80;
  localparam logic [7:0] input_timing_config_b_rst = 8'h02;
  localparam logic [7:0] input_timing_config_c_rst = 8'h80;
  localparam logic [7:0] sample_trailing_edge_rst  = 8'h00;
  localparam logic [1:0] channel_config_rst        = 2'h0;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int mode_a_bit      = 0; // in config a
  localparam int mode_p_lo_bit   = 1; // in phase config
  localparam int coarse_lo_bit   = 2; // coarse phase, two bits
  localparam int mode_p_hi_bit   = 7; // in phase config
  localparam int mode_b_bit      = 1; // in config b
  localparam int sync_edge_bit   = 5; // in config b, 1 = falling edge
  localparam int mode_c_bit      = 7; // in config c
  localparam int trail_width     = 5; // trailing edge code width

  // ------------------------------------------------------------
  // channel arrangements and timing modes
  // ------------------------------------------------------------
  localparam logic [1:0] chan_six_adc_rate   = 2'h0; // two clocks per pixel
  localparam logic [1:0] chan_six_pixel_rate = 2'h1; // one clock per pixel
  localparam logic [1:0] chan_three          = 2'h2; // one clock per pixel

  typedef enum logic [2:0] {
    hold_strobe_clocked_mode,
    strobe_sampled_mode,
    delay_line_clocked_mode,
    phase_clocked_hold_mode,
    signal_gated_hold_mode,
    phase_sampled_correlated_mode,
    strobe_gated_correlated_mode,
    invalid_mode
  } timing_mode_t;

endpackage

// ---- verilog/sample_timing_phase_control.sv ----
// sample timing controller: mode decode, phase state machine, pulse gating
// assumes all strobe and sync pins are asynchronous to clk
//
// Function
// - line sync captured on selectable clock edge
// - six-channel adc rate: pixel is two clocks
// - other arrangements: pixel is one clock
// - decode hold, strobe, delay-line modes
// - decode remaining four timing modes
// - hold-strobe mode aligns phase to hold strobe
// - other modes align phase to line sync
// - delay-line pulses only in delay-line mode
// - coarse phase from sample phase bits 3:2
// - trailing edge code in 32 binary steps
// - line sync event resets phase state machine, except in hold-strobe mode
// - three-channel offers only two coarse phases
// - gated modes AND strobes with phase
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

module sample_timing_phase_control (
  input  wire logic       clk,                   // 25 MHz master clock
  input  wire logic       arst_n,                // async reset, active low
  input  wire logic [7:0] reg_addr,              // register address
  input  wire logic [7:0] reg_wdata,             // register write data
  input  wire logic       reg_wr,                // write strobe
  input  wire logic       reg_rd,                // read strobe
  output logic      [7:0] reg_rdata,             // read data, cycle after strobe
  input  wire logic       line_sync_input,       // line sync pin
  input  wire logic       sample_strobe,         // external sample strobe pin
  input  wire logic       hold_strobe,           // external hold strobe pin
  input  wire logic       reference_strobe,      // reference strobe pin
  input  wire logic       signal_strobe,         // signal strobe pin
  output logic            selected_sample_phase, // selected phase level
  output logic            clamp_pulse,           // internal clamp pulse
  output logic            sample_pulse,          // internal sample pulse
  output logic      [4:0] trailing_edge_code,    // applied delay-line code
  output logic            delay_line_active      // delay-line pulses in use
);

  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg_a;      // input timing config a
    logic [7:0] phase_cfg;  // sample phase config
    logic [7:0] cfg_b;      // input timing config b
    logic [7:0] cfg_c;      // input timing config c
    logic [7:0] trail;      // trailing edge register
    logic [1:0] chan;       // channel arrangement
    logic       ls_s1;      // line sync, first stage
    logic       ls_s2;      // line sync, second stage
    logic       ls_d;       // line sync, late capture
    logic       ls_prev;    // selected line sync, previous
    logic       hs_s1;      // hold strobe, first stage
    logic       hs_s2;      // hold strobe, second stage
    logic       hs_prev;    // hold strobe, previous
    logic       ss_s1;      // sample strobe, first stage
    logic       ss_s2;      // sample strobe, second stage
    logic       ss_prev;    // sample strobe, previous
    logic       rs_s1;      // reference strobe, first stage
    logic       rs_s2;      // reference strobe, second stage
    logic       ds_s1;      // signal strobe, first stage
    logic       ds_s2;      // signal strobe, second stage
    logic       sh_win;     // sample control window
    logic [1:0] slot;       // half-pixel slot counter
    logic [1:0] coarse_act; // coarse phase in use
    logic [4:0] trail_act;  // trailing code in use
    logic       phase_o;    // phase output
    logic       clamp_o;    // clamp output
    logic       sample_o;   // sample output
    logic [4:0] code_o;     // code output
    logic       dl_o;       // delay-line output
    logic [7:0] rdata;      // read data
  } state_t;

  localparam state_t state_rst = '{
    cfg_a:     sample_timing_pkg::input_timing_config_a_rst,
    phase_cfg: sample_timing_pkg::sample_phase_config_rst,
    cfg_b:     sample_timing_pkg::input_timing_config_b_rst,
    cfg_c:     sample_timing_pkg::input_timing_config_c_rst,
    trail:     sample_timing_pkg::sample_trailing_edge_rst,
    chan:      sample_timing_pkg::channel_config_rst,
    default:   '0
  };

  state_t s_reg;  // registered state
  state_t s_next; // next state

  // ------------------------------------------------------------
  // decode of current configuration
  // ------------------------------------------------------------
  sample_timing_pkg::timing_mode_t mode;  // decoded timing mode
  logic [4:0] mode_bits;                  // the five mode bits
  logic       ls_sel;                     // line sync on chosen edge
  logic       ls_evt;                     // line sync rising event
  logic       hs_evt;                     // hold strobe rising event
  logic       ss_evt;                     // sample strobe rising event
  logic       realign;                    // phase machine reset
  logic       boundary;                   // pixel boundary this cycle
  logic       adc_rate;                   // two clocks per pixel
  logic [1:0] coarse_eff;                 // coarse phase allowed here
  logic [1:0] slot_rel;                   // slot relative to phase
  logic       phase_now;                  // phase level this cycle

  always_comb begin
    mode_bits = {s_reg.cfg_c[sample_timing_pkg::mode_c_bit],
                 s_reg.cfg_b[sample_timing_pkg::mode_b_bit],
                 s_reg.phase_cfg[sample_timing_pkg::mode_p_hi_bit],
                 s_reg.phase_cfg[sample_timing_pkg::mode_p_lo_bit],
                 s_reg.cfg_a[sample_timing_pkg::mode_a_bit]};
    unique case (mode_bits)
      5'h04:   mode = sample_timing_pkg::hold_strobe_clocked_mode;
      5'h0c:   mode = sample_timing_pkg::strobe_sampled_mode;
      5'h1c:   mode = sample_timing_pkg::delay_line_clocked_mode;
      5'h0a:   mode = sample_timing_pkg::phase_clocked_hold_mode;
      5'h0e:   mode = sample_timing_pkg::signal_gated_hold_mode;
      5'h0b:   mode = sample_timing_pkg::phase_sampled_correlated_mode;
      5'h0f:   mode = sample_timing_pkg::strobe_gated_correlated_mode;
      default: mode = sample_timing_pkg::invalid_mode;
    endcase
  end

  assign ls_sel = s_reg.cfg_b[sample_timing_pkg::sync_edge_bit] ? s_reg.ls_d : s_reg.ls_s2;
  assign ls_evt = ls_sel && !s_reg.ls_prev;
  assign hs_evt = s_reg.hs_s2 && !s_reg.hs_prev;
  assign ss_evt = s_reg.ss_s2 && !s_reg.ss_prev;

  assign realign = (mode == sample_timing_pkg::hold_strobe_clocked_mode) ? hs_evt : ls_evt;

  assign adc_rate = (s_reg.chan == sample_timing_pkg::chan_six_adc_rate);
  assign boundary = !adc_rate || !s_reg.slot[0];

  assign coarse_eff = (s_reg.chan == sample_timing_pkg::chan_three) ?
                      {s_reg.coarse_act[1], 1'b0} : s_reg.coarse_act;
  assign slot_rel   = s_reg.slot - coarse_eff;
  assign phase_now  = !slot_rel[1];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        sample_timing_pkg::input_timing_config_a_off: s_next.cfg_a = reg_wdata;
        sample_timing_pkg::sample_phase_config_off:   s_next.phase_cfg = reg_wdata;
        sample_timing_pkg::input_timing_config_b_off: s_next.cfg_b = reg_wdata;
        sample_timing_pkg::input_timing_config_c_off: s_next.cfg_c = reg_wdata;
        sample_timing_pkg::sample_trailing_edge_off:  s_next.trail = reg_wdata;
        sample_timing_pkg::channel_config_off:        s_next.chan = reg_wdata[1:0];
        default: ;
      endcase
    end
    // register reads, unmapped reads zero
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        sample_timing_pkg::input_timing_config_a_off: s_next.rdata = s_reg.cfg_a;
        sample_timing_pkg::sample_phase_config_off:   s_next.rdata = s_reg.phase_cfg;
        sample_timing_pkg::input_timing_config_b_off: s_next.rdata = s_reg.cfg_b;
        sample_timing_pkg::input_timing_config_c_off: s_next.rdata = s_reg.cfg_c;
        sample_timing_pkg::sample_trailing_edge_off:  s_next.rdata = s_reg.trail;
        sample_timing_pkg::channel_config_off:        s_next.rdata = {6'h00, s_reg.chan};
        sample_timing_pkg::timing_status_off:
          s_next.rdata = {mode, coarse_eff, s_reg.phase_o, s_reg.slot};
        default: ;
      endcase
    end
    // two-stage synchronisers
    s_next.ls_s1 = line_sync_input;
    s_next.ls_s2 = s_reg.ls_s1;
    s_next.ls_d  = s_reg.ls_s2;
    s_next.ls_prev = ls_sel;
    s_next.hs_s1 = hold_strobe;
    s_next.hs_s2 = s_reg.hs_s1;
    s_next.hs_prev = s_reg.hs_s2;
    s_next.ss_s1 = sample_strobe;
    s_next.ss_s2 = s_reg.ss_s1;
    s_next.ss_prev = s_reg.ss_s2;
    s_next.rs_s1 = reference_strobe;
    s_next.rs_s2 = s_reg.rs_s1;
    s_next.ds_s1 = signal_strobe;
    s_next.ds_s2 = s_reg.ds_s1;
    if (realign) begin
      s_next.slot = 2'h0;
    end else begin
      s_next.slot = s_reg.slot + 2'h1;
    end
    if (boundary) begin
      s_next.coarse_act = s_reg.phase_cfg[sample_timing_pkg::coarse_lo_bit +: 2];
      s_next.trail_act  = s_reg.trail[sample_timing_pkg::trail_width-1:0];
    end
    // sample control window: opens on sample strobe, closes on hold strobe
    if (ss_evt) begin
      s_next.sh_win = 1'b1;
    end else if (hs_evt) begin
      s_next.sh_win = 1'b0;
    end
    // pulse outputs per mode
    s_next.phase_o  = phase_now;
    s_next.clamp_o  = 1'b0;
    s_next.sample_o = 1'b0;
    s_next.dl_o     = 1'b0;
    s_next.code_o   = 5'h00;
    unique case (mode)
      sample_timing_pkg::hold_strobe_clocked_mode,
      sample_timing_pkg::strobe_sampled_mode: begin
        // strobe window gated by the low phase
        s_next.sample_o = s_reg.sh_win && !phase_now;
      end
      sample_timing_pkg::delay_line_clocked_mode: begin
        s_next.sample_o = !phase_now;
        s_next.dl_o     = 1'b1;
        s_next.code_o   = s_reg.trail_act;
      end
      sample_timing_pkg::phase_clocked_hold_mode: begin
        // sample from the low phase
        s_next.sample_o = !phase_now;
      end
      sample_timing_pkg::signal_gated_hold_mode: begin
        s_next.sample_o = s_reg.ds_s2 && !phase_now;
      end
      sample_timing_pkg::phase_sampled_correlated_mode: begin
        // clamp high phase, sample low phase
        s_next.clamp_o  = phase_now;
        s_next.sample_o = !phase_now;
      end
      sample_timing_pkg::strobe_gated_correlated_mode: begin
        s_next.clamp_o  = s_reg.rs_s2 && phase_now;
        s_next.sample_o = s_reg.ds_s2 && !phase_now;
      end
      default: ; // invalid setting: pulses stay low
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= state_rst;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata             = s_reg.rdata;
  assign selected_sample_phase = s_reg.phase_o;
  assign clamp_pulse           = s_reg.clamp_o;
  assign sample_pulse          = s_reg.sample_o;
  assign trailing_edge_code    = s_reg.code_o;
  assign delay_line_active     = s_reg.dl_o;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_sync_rise_edge: assert property (@(posedge clk) disable iff (!arst_n)
    (!s_reg.cfg_b[5] && !$past(s_reg.cfg_b[5]) && s_reg.ls_s2 && !s_reg.ls_prev
     && mode != sample_timing_pkg::hold_strobe_clocked_mode) |=> s_reg.slot == 2'h0)
    else $error("line sync rise did not realign phase");

  chk_sync_fall_edge: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.cfg_b[5] && $rose(s_reg.ls_s2) && $stable(s_reg.cfg_b)
     && mode != sample_timing_pkg::hold_strobe_clocked_mode && !ls_evt
     && !reg_wr) |=> ##1 s_reg.slot == 2'h0)
    else $error("late line sync capture did not realign phase");

  chk_hold_realign: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == sample_timing_pkg::hold_strobe_clocked_mode && hs_evt) |=> s_reg.slot == 2'h0)
    else $error("hold strobe did not realign phase");

  chk_mode_default: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_bits == 5'h1c) |=> (s_reg.dl_o && !s_reg.clamp_o))
    else $error("delay-line mode not applied");

  chk_corr_clamp: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == sample_timing_pkg::phase_sampled_correlated_mode) |=>
      s_reg.clamp_o == !s_reg.sample_o)
    else $error("correlated clamp and sample overlap");

  chk_trail_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.code_o != 5'h00) |-> s_reg.dl_o)
    else $error("trailing code outside delay-line mode");

  chk_gated_clamp: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == sample_timing_pkg::strobe_gated_correlated_mode) |=>
      s_reg.clamp_o == $past(s_reg.rs_s2 && phase_now))
    else $error("clamp not gated by reference strobe");

  chk_coarse_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !boundary |=> $stable(s_reg.coarse_act) && $stable(s_reg.trail_act))
    else $error("setting changed inside a pixel");

  chk_pixel_span: assert property (@(posedge clk) disable iff (!arst_n)
    (adc_rate && boundary && !realign && !reg_wr) |=> !boundary)
    else $error("adc-rate pixel shorter than two clocks");

  // every clock is a boundary outside the adc-rate arrangement
  chk_pixel_rate: assert property (@(posedge clk) disable iff (!arst_n)
    !adc_rate |=>
      s_reg.coarse_act == $past(s_reg.phase_cfg[sample_timing_pkg::coarse_lo_bit +: 2]))
    else $error("pixel-rate setting not taken next clock");

  chk_three_phase: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.chan == sample_timing_pkg::chan_three && reg_rd
     && reg_addr == sample_timing_pkg::timing_status_off) |=> !s_reg.rdata[3])
    else $error("three-channel odd coarse phase");

  chk_trail_apply: assert property (@(posedge clk) disable iff (!arst_n)
    boundary |=> s_reg.trail_act == $past(s_reg.trail[4:0]))
    else $error("trailing code not taken at boundary");

  cov_delay_code: cover property (@(posedge clk) disable iff (!arst_n)
    s_reg.dl_o && s_reg.code_o == 5'h1f);
  cov_hold_align: cover property (@(posedge clk) disable iff (!arst_n)
    mode == sample_timing_pkg::hold_strobe_clocked_mode && hs_evt);
  cov_gated_clamp: cover property (@(posedge clk) disable iff (!arst_n)
    s_reg.clamp_o && mode == sample_timing_pkg::strobe_gated_correlated_mode);
  cov_sync_late: cover property (@(posedge clk) disable iff (!arst_n)
    s_reg.cfg_b[sample_timing_pkg::sync_edge_bit] && ls_evt);
  cov_pixel_rate: cover property (@(posedge clk) disable iff (!arst_n)
    s_reg.chan == sample_timing_pkg::chan_six_pixel_rate && s_reg.dl_o);

endmodule

// ---- bench/host_timing_model.sv ----
// host timing model: drives line sync and strobe pins of the sample timing block
// assumes bench commands arrive as one-cycle pulses sampled on clk
`timescale 1ns/10ps

module host_timing_model #(
  parameter int sync_hold = 4          // clocks line sync stays at each level
) (
  input  wire logic clk,               // master clock
  input  wire logic sync_req,          // start one line sync pulse
  input  wire logic window_req,        // start one sample/hold pair
  input  wire logic ref_level,         // wanted reference strobe level
  input  wire logic sig_level,         // wanted signal strobe level
  output logic      line_sync_input,   // line sync pin
  output logic      sample_strobe,     // sample strobe pin
  output logic      hold_strobe,       // hold strobe pin
  output logic      reference_strobe,  // reference strobe pin
  output logic      signal_strobe      // signal strobe pin
);
  int sync_cnt = 0;                    // clocks left in high plus low spell
  int win_cnt  = 0;                    // steps left in sample/hold pair

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  initial begin
    line_sync_input = 1'b0;
    sample_strobe = 1'b0;
    hold_strobe = 1'b0;
    reference_strobe = 1'b0;
    signal_strobe = 1'b0;
  end

  always @(posedge clk) begin
    reference_strobe <= ref_level;
    signal_strobe <= sig_level;
    if (sync_req && sync_cnt == 0) begin
      sync_cnt <= 2 * sync_hold;
      line_sync_input <= 1'b1;
    end else if (sync_cnt > 0) begin
      sync_cnt <= sync_cnt - 1;
      line_sync_input <= (sync_cnt - 1 > sync_hold);
    end
    // sample leads hold by one clock
    if (window_req && win_cnt == 0) begin
      win_cnt <= 2;
      sample_strobe <= 1'b1;
    end else if (win_cnt > 0) begin
      win_cnt <= win_cnt - 1;
      hold_strobe <= (win_cnt == 2);
      sample_strobe <= (win_cnt == 2);
    end
  end
endmodule

// ---- bench/sample_timing_phase_control_test.sv ----
// self-checking bench for the sample timing phase controller
// assumes the package and the host timing model are compiled first
`timescale 1ns/10ps

module sample_timing_phase_control_test;
  logic       clk = 1'b0;                                  // master clock
  logic       arst_n = 1'b0;                               // reset, active low
  logic [7:0] reg_addr = 8'h00;                            // register address
  logic [7:0] reg_wdata = 8'h00;                           // write data
  logic       reg_wr = 1'b0;                               // write strobe
  logic       reg_rd = 1'b0;                               // read strobe
  logic       sync_req = 1'b0;                             // model command
  logic       window_req = 1'b0;                           // model command
  logic       ref_level = 1'b0;                            // model command
  logic       sig_level = 1'b0;                            // model command
  logic [7:0] reg_rdata, rd_val;                           // read data, last read
  logic       line_sync_input, sample_strobe, hold_strobe; // pins
  logic       reference_strobe, signal_strobe;             // pins
  logic       selected_sample_phase, clamp_pulse;          // outputs
  logic       sample_pulse, delay_line_active;             // outputs
  logic [4:0] trailing_edge_code;                          // applied code
  int         bad_count = 0;                               // mismatches
  int         checked = 0;                                 // comparisons
  int         cycles = 0;                                  // timeout count
  // mode bits {0x05[7],0x04[1],0x02[7],0x02[1],0x00[0]} in enum order
  // only the last word lies outside the seven, to see pulses stay low
  localparam logic [4:0] mode_bits [8] = '{5'h04, 5'h0c, 5'h1c, 5'h0a,
                                           5'h0e, 5'h0b, 5'h0f, 5'h10};
  localparam logic [7:0] rst_addr [6] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h36, 8'h07};
  localparam logic [7:0] rst_val [6] = '{8'h00, 8'h80, 8'h02, 8'h80, 8'h00, 8'h00};

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  sample_timing_phase_control dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .line_sync_input, .sample_strobe, .hold_strobe,
    .reference_strobe, .signal_strobe, .selected_sample_phase, .clamp_pulse,
    .sample_pulse, .trailing_edge_code, .delay_line_active);
  host_timing_model host (.clk, .sync_req, .window_req, .ref_level, .sig_level,
    .line_sync_input, .sample_strobe, .hold_strobe, .reference_strobe, .signal_strobe);

  // ------------------------------------------------------------
  // clock, timeout and verdict
  // ------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands the cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic set_mode(input logic [4:0] m, input logic [1:0] crs, input logic edge_sel);
    wr(8'h05, {m[4], 7'h00});
    wr(8'h04, {2'h0, edge_sel, 3'h0, m[3], 1'b0});
    wr(8'h02, {m[2], 3'h0, crs, m[1], 1'b0});
    wr(8'h00, {7'h00, m[0]});
    repeat (3) @(posedge clk);
  endtask

  // slot is forced to 0 three edges after the pin rises, one more on falling capture
  task automatic sync_slot(input logic [1:0] exp);
    @(posedge clk);
    sync_req <= 1'b1;
    @(posedge clk);
    sync_req <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h08);
    chk("slot", {6'h00, exp}, {6'h00, rd_val[1:0]});
    repeat (8) @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(rst_addr[i]);
      chk("reset value", rst_val[i], rd_val);
    end
    rd(8'h10);
    chk("unmapped", 8'h00, rd_val);
    wr(8'h08, 8'h00);
    rd(8'h08);
    chk("default mode", 8'h02, {5'h00, rd_val[7:5]});
    wr(8'h36, 8'h13);
    // every decode, active delay line only in its own mode
    for (int i = 0; i < 8; i++) begin
      set_mode(mode_bits[i], 2'h3, 1'b0);
      rd(8'h08);
      chk("mode", 8'(i), {5'h00, rd_val[7:5]});
      chk("line active", {7'h00, i == 2}, {7'h00, delay_line_active});
      chk("edge code", (i == 2) ? 8'h13 : 8'h00, {3'h0, trailing_edge_code});
    end
    set_mode(5'h1c, 2'h3, 1'b0);
    wr(8'h36, 8'hff);
    repeat (4) @(posedge clk);
    #1 chk("edge code max", 8'h1f, {3'h0, trailing_edge_code});
    // pixel-rate arrangement: the code is taken at the very next clock
    wr(8'h07, 8'h01);
    wr(8'h36, 8'h0a);
    repeat (2) @(posedge clk);
    #1 chk("edge code pixel rate", 8'h0a, {3'h0, trailing_edge_code});
    wr(8'h07, 8'h00);
    rd(8'h08);
    chk("coarse", 8'h03, {6'h00, rd_val[4:3]});
    wr(8'h07, 8'h02);
    repeat (3) @(posedge clk);
    rd(8'h08);
    chk("coarse three ch", 8'h02, {6'h00, rd_val[4:3]});
    wr(8'h07, 8'h00);
    sync_slot(2'h2);
    set_mode(5'h1c, 2'h3, 1'b1);
    sync_slot(2'h1);
    // hold-strobe mode takes its alignment from the hold strobe
    set_mode(5'h04, 2'h3, 1'b0);
    window_req <= 1'b1;
    @(posedge clk);
    window_req <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h08);
    chk("hold slot", 8'h01, {6'h00, rd_val[1:0]});
    // gated correlated mode: clamp is phase gated by reference strobe, sample the inverse gated by signal strobe
    set_mode(5'h0f, 2'h0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      ref_level <= (k == 0);
      sig_level <= (k == 1);
      repeat (6) @(posedge clk);
      for (int c = 0; c < 4; c++) begin
        @(posedge clk);
        #1 chk("clamp", {7'h00, (k == 0) & selected_sample_phase}, {7'h00, clamp_pulse});
        chk("sample", {7'h00, (k == 1) & ~selected_sample_phase}, {7'h00, sample_pulse});
      end
    end
    test_done();
  end
endmodule
